// File: hdl/bce_top.sv
// Condition evaluator with its flag register and an APB register slave.
//
// What this block does
// - Code 1000 is always satisfied and code 0000 never, whatever flags.
// - Code 0111 is true with carry set and code 1111 with carry clear.
// - Code 0110 is true with zero set and code 1110 with zero clear.
// - Codes 1101/0101 test sign clear/set, 0100/1100 overflow set/clear.
// - Code 1001 needs sign XOR overflow at 0, code 0001 needs it at 1.
// - Code 1010 needs zero OR (sign XOR overflow) at 0, code 0010 at 1.
// - Code 1011 needs carry and zero both 0, code 0011 carry OR zero at 1.
// - The flag register at 252 holds six flags; four of them (carry, zero, sign, overflow) feed the evaluation.
`timescale 1ns/100ps
`include "bce_cfg.svh"

module bce_top #(
    parameter int ADDR_W = 12,
    parameter int CNT_W  = 16
) (
    // Clock and reset.
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_n_i,
    // APB slave.
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [ADDR_W-1:0]         paddr_i,
    input  wire logic [31:0]               pwdata_i,
    input  wire logic [3:0]                pstrb_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    // Core side: flag updates and condition requests.
    input  wire bce_pkg::bce_flag_upd_type core_flag_upd_i,
    input  wire bce_pkg::bce_cc_type       core_cc_i,
    input  wire logic                      core_cc_valid_i,
    output logic                           core_cc_true_o,
    output bce_pkg::bce_flags_type         flags_o
);

    // ============================================================
    // Declarations.
    bce_pkg::bce_flags_type flags;
    bce_pkg::bce_flags_type next_flags;
    bce_pkg::bce_cc_type    query_cc;
    bce_pkg::bce_cc_type    next_query_cc;
    logic [CNT_W-1:0]       taken_count;
    logic [CNT_W-1:0]       next_taken_count;
    logic [31:0]            rd_data;
    logic [31:0]            next_rd_data;
    logic                   rd_err;
    logic                   next_rd_err;
    logic                   query_true;
    logic                   apb_setup;
    logic                   apb_access;
    logic                   wr_flags;
    logic                   wr_query;
    logic                   addr_flags;
    logic                   addr_query;
    logic                   addr_status;
    logic                   addr_hit;

    // ============================================================
    // Evaluators: one for the core, one for software queries.
    bce_cond_eval u_core_eval (
        .flags_i   (flags),
        .cc_i      (core_cc_i),
        .cc_true_o (core_cc_true_o)
    );

    bce_cond_eval u_query_eval (
        .flags_i   (flags),
        .cc_i      (query_cc),
        .cc_true_o (query_true)
    );

    assign flags_o = flags;

    // ============================================================
    // APB address decode.
    always_comb begin
        addr_flags  = 1'b0;
        addr_query  = 1'b0;
        addr_status = 1'b0;
        if (paddr_i == `BCE_OFF_FLAGS) begin
            addr_flags = 1'b1;
        end else if (paddr_i == `BCE_OFF_QUERY) begin
            addr_query = 1'b1;
        end else if (paddr_i == `BCE_OFF_STATUS) begin
            addr_status = 1'b1;
        end
    end

    assign addr_hit   = addr_flags | addr_query | addr_status;
    assign apb_setup  = psel_i && !penable_i;
    assign apb_access = psel_i && penable_i;
    // Zero wait states: every access phase completes at its first edge.
    assign pready_o   = apb_access;
    assign wr_flags   = apb_access && pwrite_i && addr_flags
                        && pstrb_i[`BCE_STRB_LANE0];
    assign wr_query   = apb_access && pwrite_i && addr_query
                        && pstrb_i[`BCE_STRB_LANE0];

    // ============================================================
    // Flag register next value. The core's own update wins over a
    // software write in the same cycle, since the instruction stream
    // must never see a stale result of its own arithmetic.
    always_comb begin
        next_flags = flags;
        if (core_flag_upd_i.valid) begin
            next_flags = core_flag_upd_i.flags;
        end else if (wr_flags) begin
            next_flags = pwdata_i[`BCE_FLAGS_MSB:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags <= `BCE_FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // ============================================================
    // Query code register, written by software to probe the flags.
    always_comb begin
        next_query_cc = query_cc;
        if (wr_query) begin
            next_query_cc = bce_pkg::bce_cc_type'(pwdata_i[`BCE_QUERY_MSB:0]);
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            query_cc <= bce_pkg::bce_cc_type'(`BCE_QUERY_RESET);
        end else begin
            query_cc <= next_query_cc;
        end
    end

    // ============================================================
    // Count of requests that came out true; it saturates rather than
    // wrapping so a long run never reads back as a small number.
    always_comb begin
        next_taken_count = taken_count;
        if (core_cc_valid_i && core_cc_true_o
            && taken_count != `BCE_COUNT_MAX) begin
            next_taken_count = taken_count + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            taken_count <= `BCE_COUNT_RESET;
        end else begin
            taken_count <= next_taken_count;
        end
    end

    // ============================================================
    // Read data and error are captured in the setup cycle so that both
    // leave flip-flops during the access phase.
    always_comb begin
        next_rd_data = rd_data;
        next_rd_err  = rd_err;
        if (apb_setup) begin
            next_rd_data = 32'h0000_0000;
            next_rd_err  = !addr_hit;
            if (addr_flags) begin
                next_rd_data[`BCE_FLAGS_MSB:0] = flags;
            end else if (addr_query) begin
                next_rd_data[`BCE_QUERY_MSB:0] = query_cc;
            end else if (addr_status) begin
                next_rd_data[`BCE_ST_QUERY_BIT] = query_true;
                next_rd_data[`BCE_ST_CORE_BIT]  = core_cc_true_o;
                next_rd_data[`BCE_ST_CNT_MSB:`BCE_ST_CNT_LSB] = taken_count;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data <= `BCE_RDATA_RESET;
            rd_err  <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            rd_err  <= next_rd_err;
        end
    end

    assign prdata_o  = (apb_access && !pwrite_i) ? rd_data : 32'h0000_0000;
    assign pslverr_o = apb_access && rd_err;

    // ============================================================
    // Checks on the evaluator, the flag register, the true-result counter and unmapped addresses.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_flag_write;
        wr_flags && !core_flag_upd_i.valid;
    endsequence

    sequence s_core_update;
        core_flag_upd_i.valid;
    endsequence

    a_fixed_codes:
    assert property ((core_cc_i == bce_pkg::bce_cc_always |-> core_cc_true_o)
        and (core_cc_i == bce_pkg::bce_cc_never |-> !core_cc_true_o))
    else $error("Fixed condition codes answered wrongly.");

    a_carry_pair:
    assert property (
        (core_cc_i == bce_pkg::bce_cc_unsigned_below
         || core_cc_i == bce_pkg::bce_cc_unsigned_at_least)
        |-> core_cc_true_o == (flags_o.carry
            ^ (core_cc_i == bce_pkg::bce_cc_unsigned_at_least)))
    else $error("Carry condition does not follow the carry flag.");

    a_zero_pair:
    assert property (
        (core_cc_i == bce_pkg::bce_cc_same_value_cond
         || core_cc_i == bce_pkg::bce_cc_differ_cond)
        |-> core_cc_true_o == (flags_o.zero
            ^ (core_cc_i == bce_pkg::bce_cc_differ_cond)))
    else $error("Zero condition does not follow the zero flag.");

    a_sign_wrap:
    assert property (
        (core_cc_i == bce_pkg::bce_cc_sign_negative
            |-> core_cc_true_o == flags_o.sign)
        and (core_cc_i == bce_pkg::bce_cc_sign_positive
            |-> core_cc_true_o != flags_o.sign)
        and (core_cc_i == bce_pkg::bce_cc_arith_wrap_set
            |-> core_cc_true_o == flags_o.overflow)
        and (core_cc_i == bce_pkg::bce_cc_arith_wrap_clear
            |-> core_cc_true_o != flags_o.overflow))
    else $error("Sign or overflow condition answered wrongly.");

    a_signed_less:
    assert property (
        (core_cc_i == bce_pkg::bce_cc_signed_below
            |-> core_cc_true_o == (flags_o.sign != flags_o.overflow))
        and (core_cc_i == bce_pkg::bce_cc_signed_at_least
            |-> core_cc_true_o == (flags_o.sign == flags_o.overflow)))
    else $error("Signed below or at-least answered wrongly.");

    a_signed_above:
    assert property (
        (core_cc_i == bce_pkg::bce_cc_signed_at_most && flags_o.zero
            |-> core_cc_true_o)
        and (core_cc_i == bce_pkg::bce_cc_signed_above
            |-> core_cc_true_o == (!flags_o.zero
                && flags_o.sign == flags_o.overflow))
        and (core_cc_i == bce_pkg::bce_cc_signed_at_most && !flags_o.zero
            |-> core_cc_true_o == (flags_o.sign != flags_o.overflow)))
    else $error("Signed above or at-most answered wrongly.");

    a_unsigned_above:
    assert property (
        (core_cc_i == bce_pkg::bce_cc_unsigned_above
            |-> core_cc_true_o == !(flags_o.carry || flags_o.zero))
        and (core_cc_i == bce_pkg::bce_cc_unsigned_at_most
            |-> core_cc_true_o == (flags_o.carry || flags_o.zero)))
    else $error("Unsigned above or at-most answered wrongly.");

    a_flag_write:
    assert property (s_flag_write
        |=> flags_o == $past(pwdata_i[`BCE_FLAGS_MSB:0]))
    else $error("Software write did not reach the flag register.");

    a_core_wins:
    assert property (s_core_update |=> flags_o == $past(core_flag_upd_i.flags))
    else $error("Core flag update was not taken.");

    a_flag_read:
    assert property (apb_setup && !pwrite_i && addr_flags
        && !core_flag_upd_i.valid
        |=> prdata_o[`BCE_FLAGS_MSB:0] == flags_o && pready_o && !pslverr_o)
    else $error("Flag register read returned a wrong value.");

    a_same_cycle:
    assert property (s_core_update ##1
        (core_cc_i == bce_pkg::bce_cc_same_value_cond
         && flags_o.zero != $past(flags_o.zero))
        |-> core_cc_true_o == flags_o.zero)
    else $error("Result lags a fresh flag value.");

    a_count_step:
    assert property (core_cc_valid_i && core_cc_true_o
        && taken_count != `BCE_COUNT_MAX
        |=> taken_count == $past(taken_count) + 1'b1)
    else $error("True-result counter did not advance.");

    a_bad_address:
    assert property (apb_setup && !addr_hit ##1 apb_access
        |-> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("Unmapped access was not flagged.");

endmodule

// File: hdl/bce_cfg.svh
// Address map, field positions and reset values of the condition evaluator.
`ifndef BCE_CFG_SVH
`define BCE_CFG_SVH

// ============================================================
// Register byte offsets on the APB bus.
`define BCE_OFF_FLAGS     12'h0fc
`define BCE_OFF_QUERY     12'h0f8
`define BCE_OFF_STATUS    12'h0f4

// ============================================================
// Reset values and the counter's saturation limit.
`define BCE_FLAGS_RESET   8'h00
`define BCE_RDATA_RESET   32'h0000_0000
`define BCE_QUERY_RESET   4'h0
`define BCE_COUNT_RESET   16'h0000
`define BCE_COUNT_MAX     16'hffff

// ============================================================
// Field positions inside the registers.
`define BCE_FLAGS_MSB     7
`define BCE_QUERY_MSB     3
`define BCE_ST_QUERY_BIT  0
`define BCE_ST_CORE_BIT   1
`define BCE_ST_CNT_LSB    16
`define BCE_ST_CNT_MSB    31
`define BCE_STRB_LANE0    0

`endif

// File: hdl/bce_pkg.sv
// Types shared by the condition evaluator files.
package bce_pkg;

    // ============================================================
    // Flag register layout, most significant bit first.
    typedef struct packed {
        logic carry;
        logic zero;
        logic sign;
        logic overflow;
        logic decimal_adj;
        logic half_carry;
        logic [1:0] spare;
    } bce_flags_type;

    // A flag update from the arithmetic unit of the core.
    typedef struct packed {
        logic          valid;
        bce_flags_type flags;
    } bce_flag_upd_type;

    // The sixteen condition codes.
    typedef enum logic [3:0] {
        bce_cc_never             = 4'h0,
        bce_cc_signed_below      = 4'h1,
        bce_cc_signed_at_most    = 4'h2,
        bce_cc_unsigned_at_most  = 4'h3,
        bce_cc_arith_wrap_set    = 4'h4,
        bce_cc_sign_negative     = 4'h5,
        bce_cc_same_value_cond   = 4'h6,
        bce_cc_unsigned_below    = 4'h7,
        bce_cc_always            = 4'h8,
        bce_cc_signed_at_least   = 4'h9,
        bce_cc_signed_above      = 4'ha,
        bce_cc_unsigned_above    = 4'hb,
        bce_cc_arith_wrap_clear  = 4'hc,
        bce_cc_sign_positive     = 4'hd,
        bce_cc_differ_cond       = 4'he,
        bce_cc_unsigned_at_least = 4'hf
    } bce_cc_type;

endpackage

// File: hdl/bce_cond_eval.sv
// Combinational test of one condition code against a set of flags.
`timescale 1ns/100ps

module bce_cond_eval (
    // Operands.
    input  wire bce_pkg::bce_flags_type flags_i,
    input  wire bce_pkg::bce_cc_type    cc_i,
    // Result.
    output logic                        cc_true_o
);

    logic sign_ne_wrap;

    // Signed compares share one term; the zero-or term covers the at-most pair.
    assign sign_ne_wrap = flags_i.sign ^ flags_i.overflow;

    // Pure decode, no state, so the answer follows the flags in the same cycle.
    always_comb begin
        case (cc_i)
            bce_pkg::bce_cc_never:             cc_true_o = 1'b0;
            bce_pkg::bce_cc_always:            cc_true_o = 1'b1;
            bce_pkg::bce_cc_unsigned_below:    cc_true_o = flags_i.carry;
            bce_pkg::bce_cc_unsigned_at_least: cc_true_o = !flags_i.carry;
            bce_pkg::bce_cc_same_value_cond:   cc_true_o = flags_i.zero;
            bce_pkg::bce_cc_differ_cond:       cc_true_o = !flags_i.zero;
            bce_pkg::bce_cc_sign_positive:     cc_true_o = !flags_i.sign;
            bce_pkg::bce_cc_sign_negative:     cc_true_o = flags_i.sign;
            bce_pkg::bce_cc_arith_wrap_set:    cc_true_o = flags_i.overflow;
            bce_pkg::bce_cc_arith_wrap_clear:  cc_true_o = !flags_i.overflow;
            bce_pkg::bce_cc_signed_at_least:   cc_true_o = !sign_ne_wrap;
            bce_pkg::bce_cc_signed_below:      cc_true_o = sign_ne_wrap;
            bce_pkg::bce_cc_signed_above: begin
                cc_true_o = !(flags_i.zero | sign_ne_wrap);
            end
            bce_pkg::bce_cc_signed_at_most: begin
                cc_true_o = flags_i.zero | sign_ne_wrap;
            end
            bce_pkg::bce_cc_unsigned_above: begin
                cc_true_o = !flags_i.carry && !flags_i.zero;
            end
            bce_pkg::bce_cc_unsigned_at_most: begin
                cc_true_o = flags_i.carry | flags_i.zero;
            end
            default:                           cc_true_o = 1'b0;
        endcase
    end

endmodule

// File: verification/tb_branch_condition_evaluator.sv
// Self-checking testbench of the condition evaluator top level.
`timescale 1ns/100ps
`include "bce_cfg.svh"

module tb_branch_condition_evaluator;

    // ============================================================
    // Design inputs, outputs and bench counters.
    logic                      sys_clk_i;
    logic                      reset_n_i;
    logic                      psel_i;
    logic                      penable_i;
    logic                      pwrite_i;
    logic [11:0]               paddr_i;
    logic [31:0]               pwdata_i;
    logic [3:0]                pstrb_i;
    logic [31:0]               prdata_o;
    logic                      pready_o;
    logic                      pslverr_o;
    bce_pkg::bce_flag_upd_type core_flag_upd_i;
    bce_pkg::bce_cc_type       core_cc_i;
    logic                      core_cc_valid_i;
    logic                      core_cc_true_o;
    bce_pkg::bce_flags_type    flags_o;
    int                        failures;
    int                        n_compared;
    int                        n_hits;

    bce_top bce_top_inst (
        .sys_clk_i       (sys_clk_i),
        .reset_n_i       (reset_n_i),
        .psel_i          (psel_i),
        .penable_i       (penable_i),
        .pwrite_i        (pwrite_i),
        .paddr_i         (paddr_i),
        .pwdata_i        (pwdata_i),
        .pstrb_i         (pstrb_i),
        .prdata_o        (prdata_o),
        .pready_o        (pready_o),
        .pslverr_o       (pslverr_o),
        .core_flag_upd_i (core_flag_upd_i),
        .core_cc_i       (core_cc_i),
        .core_cc_valid_i (core_cc_valid_i),
        .core_cc_true_o  (core_cc_true_o),
        .flags_o         (flags_o)
    );

    // ============================================================
    // Clock at 40 MHz.
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // ============================================================
    // Compare tasks, one per kind of result.
    task automatic check_bit(input logic got, input logic exp,
                             input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s: got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic check_word(input logic [31:0] got,
                              input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // Reference result: the low three bits pick the test, bit 3 inverts.
    function automatic logic cond_ref(input logic [3:0] cc,
                                      input bce_pkg::bce_flags_type f);
        logic sxv;
        logic base;
        sxv = f.sign ^ f.overflow;
        case (cc[2:0])
            3'd0: base = 1'b0;
            3'd1: base = sxv;
            3'd2: base = f.zero | sxv;
            3'd3: base = f.carry | f.zero;
            3'd4: base = f.overflow;
            3'd5: base = f.sign;
            3'd6: base = f.zero;
            default: base = f.carry;
        endcase
        return base ^ cc[3];
    endfunction

    // One APB transfer; waits for pready under a bound, never a fixed count.
    task automatic apb_xfer(input logic wr, input logic [11:0] addr,
                            input logic [31:0] wdata,
                            input logic [3:0] strb,
                            output logic [31:0] rdata, output logic err);
        int waited;
        waited = 0;
        @(posedge sys_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= addr;
        pwdata_i  <= wdata;
        pstrb_i   <= strb;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        // The answer is taken at the rising edge where pready is high,
        // and the request is dropped at that same edge.
        @(posedge sys_clk_i);
        while (pready_o !== 1'b1 && waited < 50) begin
            @(posedge sys_clk_i);
            waited++;
        end
        check_bit(waited < 50, 1'b1, "pready wait");
        rdata = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // ============================================================
    // Scenario: reset values of every register and of the flag output.
    task automatic test_reset_values();
        logic [31:0] d;
        logic        e;
        check_word({24'h00_0000, flags_o}, 32'h0000_0000,
                   "flags_o");
        apb_xfer(1'b0, `BCE_OFF_FLAGS, 32'h0000_0000, 4'hf, d, e);
        check_word(d, 32'h0000_0000, "flags reset");
        apb_xfer(1'b0, `BCE_OFF_QUERY, 32'h0000_0000, 4'hf, d, e);
        check_word(d, 32'h0000_0000, "query reset");
        apb_xfer(1'b0, `BCE_OFF_STATUS, 32'h0000_0000, 4'hf, d, e);
        check_word(d, 32'h0000_0000, "status reset");
        check_bit(e, 1'b0, "status err");
    endtask

    // Scenario: every code against every carry/zero/sign/overflow mix,
    // with the code changing each cycle so a pipeline stage would show.
    // The sweep starts at the zero test, so the first code after each
    // flag load probes a freshly loaded zero flag.
    task automatic test_core_codes();
        bce_pkg::bce_flags_type f;
        logic [3:0]             cc;
        for (int n = 0; n < 16; n++) begin
            f = {n[3:0], n[3:0]};
            @(posedge sys_clk_i);
            core_flag_upd_i <= {1'b1, f};
            @(posedge sys_clk_i);
            core_flag_upd_i <= {1'b0, f};
            for (int c = 0; c < 16; c++) begin
                cc = c[3:0] + 4'h6;
                core_cc_i       <= bce_pkg::bce_cc_type'(cc);
                core_cc_valid_i <= 1'b1;
                @(negedge sys_clk_i);
                check_word({24'h00_0000, flags_o}, {24'h00_0000, f},
                           "flags load");
                check_bit(core_cc_true_o,
                          cond_ref(cc, f),
                          "core result");
                if (cond_ref(cc, f)) begin
                    n_hits++;
                end
                @(posedge sys_clk_i);
            end
            core_cc_valid_i <= 1'b0;
        end
    endtask

    // Scenario: flags written by software feed the second evaluator.
    task automatic test_query_regs();
        logic [31:0] d;
        logic [7:0]  fv;
        logic        e;
        apb_xfer(1'b0, `BCE_OFF_STATUS, 32'h0000_0000, 4'hf, d, e);
        check_word({16'h0000, d[31:16]}, {16'h0000, n_hits[15:0]},
                   "hit count");
        for (int k = 0; k < 2; k++) begin
            fv = (k == 0) ? 8'ha0 : 8'h5f;
            apb_xfer(1'b1, `BCE_OFF_FLAGS, {24'hff_ffff, fv}, 4'hf, d, e);
            apb_xfer(1'b0, `BCE_OFF_FLAGS, 32'h0000_0000, 4'hf, d, e);
            check_word(d, {24'h00_0000, fv}, "flags readback");
            for (int c = 0; c < 16; c++) begin
                apb_xfer(1'b1, `BCE_OFF_QUERY, c, 4'h1, d, e);
                apb_xfer(1'b0, `BCE_OFF_STATUS, 32'h0000_0000, 4'hf, d, e);
                check_bit(d[0],
                          cond_ref(c[3:0], fv),
                          "query result");
                check_bit(d[1], cond_ref(core_cc_i, fv),
                          "core bit");
            end
        end
    endtask

    // Scenario: unmapped address, read-only status, write without the lane-0 strobe.
    task automatic test_refusals();
        logic [31:0] d;
        logic        e;
        apb_xfer(1'b0, 12'h000, 32'h0000_0000, 4'hf, d, e);
        check_bit(e, 1'b1, "unmapped read err");
        check_word(d, 32'h0000_0000, "unmapped read data");
        apb_xfer(1'b1, 12'h100, 32'hffff_ffff, 4'hf, d, e);
        check_bit(e, 1'b1, "unmapped write err");
        apb_xfer(1'b1, `BCE_OFF_STATUS, 32'hffff_ffff, 4'hf, d, e);
        check_bit(e, 1'b0, "status write err");
        apb_xfer(1'b0, `BCE_OFF_STATUS, 32'h0000_0000, 4'hf, d, e);
        check_word({16'h0000, d[31:16]}, {16'h0000, n_hits[15:0]},
                   "count kept");
        apb_xfer(1'b1, `BCE_OFF_FLAGS, 32'h0000_0033, 4'he, d, e);
        // The core update is sampled one edge later, after the kept
        // value is looked at; held across a full write it must win.
        core_flag_upd_i <= {1'b1, 8'h3c};
        @(negedge sys_clk_i);
        check_word({24'h00_0000, flags_o}, 32'h0000_005f,
                   "flags kept");
        apb_xfer(1'b1, `BCE_OFF_FLAGS, 32'h0000_0033, 4'hf, d, e);
        core_flag_upd_i <= {1'b0, 8'h3c};
        @(negedge sys_clk_i);
        check_word({24'h00_0000, flags_o}, 32'h0000_003c,
                   "core wins");
    endtask

    // ============================================================
    // Verdict and end of run.
    task automatic stop_test();
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 530 cycles; allow 20000.
    initial begin
        #(25 * 20000);
        failures++;
        stop_test();
    end

    // Main sequence; reset held for 8 cycles.
    initial begin
        reset_n_i       = 1'b0;
        psel_i          = 1'b0;
        penable_i       = 1'b0;
        pwrite_i        = 1'b0;
        paddr_i         = 12'h000;
        pwdata_i        = 32'h0000_0000;
        pstrb_i         = 4'h0;
        core_flag_upd_i = '0;
        core_cc_i       = bce_pkg::bce_cc_never;
        core_cc_valid_i = 1'b0;
        failures        = 0;
        n_compared      = 0;
        n_hits          = 0;
        repeat (8) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        test_reset_values();
        test_core_codes();
        test_query_regs();
        test_refusals();
        stop_test();
    end

endmodule
